// File: core/afo_pkg.sv
// Functional notes
// - After any shift-out the consumer returns the strobe low before another.
// - Normally wait for the ready flag before each strobe pulse.
// - Burst producer must never overfill the device storage.
// - Widened devices need their ready flags ANDed externally.
// - Widened hold-high input use needs extra logic for composite input ready.
package afo_pkg;

  // Word width of the device data output bus.
  localparam int WORD_WIDTH = 4;
  // Word capacity of one device.
  localparam int DEVICE_DEPTH = 16;
  // Local buffer depth between the pins and the user port.
  localparam int BUFFER_DEPTH = 4;

  // Clock period of CORE_CLK in ns.
  localparam int CLK_PERIOD_NS = 10;
  // Highest burst strobe rate in MHz.
  localparam int BURST_RATE_MHZ = 35;
  // Each strobe phase in burst mode lasts at least half a burst period, rounded up.
  localparam int BURST_PHASE_CYC =
    (1000 + 2 * BURST_RATE_MHZ * CLK_PERIOD_NS - 1) / (2 * BURST_RATE_MHZ * CLK_PERIOD_NS);
  // Master reset pulse width in ns, and its cycle count rounded up.
  localparam int RESET_PULSE_NS = 100;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least strobe phase width in flag-checked mode, in ns and cycles.
  localparam int STROBE_MIN_NS = 20;
  localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of the phase counters.
  localparam int COUNT_WIDTH = 4;

  // Pin inputs from the device, carried through the synchroniser as one word.
  typedef struct packed {
    logic ready;
    logic [WORD_WIDTH-1:0] data;
  } afo_pins_type;

  // Pin outputs toward the device.
  typedef struct packed {
    logic shift_out;
    logic master_reset;
    logic output_enable_n;
  } afo_drive_type;

  // Controller states.
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_IDLE = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_STROBE_HI = 3'b011,
    ST_STROBE_LO = 3'b100,
    ST_HOLD = 3'b101,
    ST_BURST_LO = 3'b110,
    ST_BURST_HI = 3'b111
  } afo_state_type;

endpackage

// File: core/afo_fifo.sv
// Small word buffer with valid/ready on both sides.
module afo_fifo
  import afo_pkg::*;
#(
  parameter int WIDTH = WORD_WIDTH,
  parameter int DEPTH = BUFFER_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (count != (PTR_W+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  ////////////////////////////////////////////////////////////////////////////
  // Storage is written only; pointers wrap at the depth, not at a power of two.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointer and count bookkeeping.
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// File: core/afo_host.sv
// Controller that drains the output side of an elastic FIFO device.
module afo_host
  import afo_pkg::*;
#(
  parameter int WIDTH = WORD_WIDTH,
  parameter int DEPTH = BUFFER_DEPTH,
  parameter int DEV_DEPTH = DEVICE_DEPTH
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic RESET_DEVICE,
  input wire logic BURST_START,
  input wire logic [4:0] BURST_WORDS,
  input wire logic HOLD_MODE,
  input wire logic [WIDTH-1:0] DATA_OUT_BUS,
  input wire logic OUTPUT_READY_FLAG,
  output logic SHIFT_OUT,
  output logic MASTER_RESET,
  output logic OUTPUT_ENABLE_N,
  output logic [WIDTH-1:0] WORD_DATA,
  output logic WORD_VALID,
  input wire logic WORD_READY,
  output logic BUSY
);

  afo_pins_type pins_meta;
  afo_pins_type pins_sync;
  afo_drive_type drive;
  afo_state_type state;
  logic [COUNT_WIDTH-1:0] phase_count;
  logic [4:0] burst_left;
  logic [WIDTH-1:0] capture_data;
  logic push_valid;
  logic push_ready;
  logic fifo_valid;
  logic [WIDTH-1:0] fifo_data;

  // Phase counter expiry, used by several states.
  function automatic logic phase_done(input logic [COUNT_WIDTH-1:0] cnt);
    return cnt == '0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser for the device pins; only the second stage is read.
  // composite ready input
  // Devices placed side by side have their ready flags ANDed ahead of this pin;
  // the extra gate delay is absorbed by the synchroniser lag.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= {OUTPUT_READY_FLAG, DATA_OUT_BUS};
      pins_sync <= pins_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer: reset pulse, flag-checked reads, held strobe and bursts.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state <= ST_RESET;
      phase_count <= COUNT_WIDTH'(RESET_PULSE_CYC);
      burst_left <= '0;
      capture_data <= '0;
      push_valid <= 1'b0;
      drive.shift_out <= 1'b0;
      drive.master_reset <= 1'b1;
      drive.output_enable_n <= 1'b1;
    end else begin
      push_valid <= 1'b0;
      if (!phase_done(phase_count)) begin
        phase_count <= phase_count - 1'b1;
      end
      case (state)
        // reset pulse width
        // The device clears its control state while this is high.
        ST_RESET: begin
          drive.master_reset <= 1'b1;
          drive.shift_out <= 1'b0;
          if (phase_done(phase_count)) begin
            drive.master_reset <= 1'b0;
            drive.output_enable_n <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (RESET_DEVICE) begin
            drive.output_enable_n <= 1'b1;
            phase_count <= COUNT_WIDTH'(RESET_PULSE_CYC);
            state <= ST_RESET;
          end else if (BURST_START && BURST_WORDS != '0) begin
            burst_left <= (BURST_WORDS > 5'(DEV_DEPTH)) ? 5'(DEV_DEPTH) : BURST_WORDS;
            phase_count <= COUNT_WIDTH'(BURST_PHASE_CYC);
            state <= ST_BURST_LO;
          end else if (pins_sync.ready && push_ready) begin
            // wait for ready
            // One extra cycle lets the data bits settle past the flag.
            state <= ST_CAPTURE;
          end else if (HOLD_MODE && !pins_sync.ready && push_ready) begin
            // output strobe only
            // A composite input-ready pulse for a widened producer is built by the
            // producer's logic; this block only holds the output strobe.
            // hold strobe high
            drive.shift_out <= 1'b1;
            state <= ST_HOLD;
          end
        end
        ST_CAPTURE: begin
          capture_data <= pins_sync.data;
          push_valid <= 1'b1;
          drive.shift_out <= 1'b1;
          phase_count <= COUNT_WIDTH'(STROBE_MIN_CYC);
          state <= ST_STROBE_HI;
        end
        // busy seen before release
        // Holding until the synchronised flag falls keeps a stale high flag
        // from starting a second read of the same word.
        ST_STROBE_HI: begin
          if (phase_done(phase_count) && !pins_sync.ready) begin
            drive.shift_out <= 1'b0;
            phase_count <= COUNT_WIDTH'(STROBE_MIN_CYC);
            state <= ST_STROBE_LO;
          end
        end
        ST_STROBE_LO: begin
          if (phase_done(phase_count)) begin
            state <= ST_IDLE;
          end
        end
        // Limitation: a ready pulse narrower than one clock period can be
        // missed here; the strobe then stays high until the next word or until HOLD_MODE falls.
        ST_HOLD: begin
          if (pins_sync.ready) begin
            capture_data <= pins_sync.data;
            push_valid <= 1'b1;
            drive.shift_out <= 1'b0;
            phase_count <= COUNT_WIDTH'(STROBE_MIN_CYC);
            state <= ST_STROBE_LO;
          end else if (!HOLD_MODE) begin
            drive.shift_out <= 1'b0;
            phase_count <= COUNT_WIDTH'(STROBE_MIN_CYC);
            state <= ST_STROBE_LO;
          end
        end
        // burst low phase
        // The low phase also covers the synchroniser lag, so the sampled word
        // is the one the previous falling edge moved into the output stage.
        ST_BURST_LO: begin
          if (phase_done(phase_count) && push_ready) begin
            capture_data <= pins_sync.data;
            push_valid <= 1'b1;
            drive.shift_out <= 1'b1;
            burst_left <= burst_left - 1'b1;
            phase_count <= COUNT_WIDTH'(BURST_PHASE_CYC);
            state <= ST_BURST_HI;
          end
        end
        ST_BURST_HI: begin
          if (phase_done(phase_count)) begin
            drive.shift_out <= 1'b0;
            phase_count <= COUNT_WIDTH'(BURST_PHASE_CYC + 2);
            state <= (burst_left == '0) ? ST_STROBE_LO : ST_BURST_LO;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Captured words wait here until the user side takes them; a full buffer
  // stalls every read path above through push_ready.
  afo_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_buffer (
    .clk(CORE_CLK),
    .reset(RESET),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(capture_data),
    .out_valid(fifo_valid),
    .out_ready(WORD_READY),
    .out_data(fifo_data)
  );

  // Pin and user outputs.
  assign SHIFT_OUT = drive.shift_out;
  assign MASTER_RESET = drive.master_reset;
  assign OUTPUT_ENABLE_N = drive.output_enable_n;
  assign WORD_DATA = fifo_data;
  assign WORD_VALID = fifo_valid;
  assign BUSY = (state != ST_IDLE);

endmodule

// File: verif/afo_host_monitor.sv
module afo_host_monitor
  import afo_pkg::*;
#(
  parameter int WIDTH = WORD_WIDTH
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic HOLD_MODE,
  input wire logic SHIFT_OUT,
  input wire logic MASTER_RESET,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic [WIDTH-1:0] WORD_DATA,
  input wire logic WORD_VALID,
  input wire logic WORD_READY
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // Hold mode is left out, because there the strobe may drop after one cycle.
  sequence strobe_rise;
    $rose(SHIFT_OUT) && !HOLD_MODE;
  endsequence
  sequence strobe_fall;
    $fell(SHIFT_OUT) && !HOLD_MODE;
  endsequence
  AST_HIGH_PHASE: assert property (strobe_rise |=> SHIFT_OUT)
    else $error("strobe high phase too short");
  AST_LOW_PHASE: assert property (strobe_fall |=> !SHIFT_OUT)
    else $error("strobe low phase too short");
  AST_QUIET_RESET: assert property (MASTER_RESET |-> !SHIFT_OUT)
    else $error("strobe during device reset");
  AST_RESET_WIDTH: assert property ($fell(RESET) |-> MASTER_RESET [*8])
    else $error("device reset pulse too short");
  AST_DEVICE_RESET_WIDTH: assert property ($rose(MASTER_RESET) |-> MASTER_RESET [*8])
    else $error("requested device reset pulse too short");
  AST_ENABLE: assert property ($fell(MASTER_RESET) |-> !OUTPUT_ENABLE_N)
    else $error("outputs not enabled after reset");
  AST_WORD_HOLD: assert property (WORD_VALID && !WORD_READY |=>
    WORD_VALID && $stable(WORD_DATA))
    else $error("word changed before it was taken");
endmodule
bind afo_host afo_host_monitor #(.WIDTH(WIDTH)) afo_host_monitor_inst (
  .CORE_CLK(CORE_CLK),
  .RESET(RESET),
  .HOLD_MODE(HOLD_MODE),
  .SHIFT_OUT(SHIFT_OUT),
  .MASTER_RESET(MASTER_RESET),
  .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
  .WORD_DATA(WORD_DATA),
  .WORD_VALID(WORD_VALID),
  .WORD_READY(WORD_READY)
);

// File: verif/afo_device_model.sv
module afo_device_model
  import afo_pkg::*;
#(
  parameter int RIPPLE_NS = 3,
  parameter int PULSE_NS = 40
) (
  input wire logic master_reset,
  input wire logic shift_out,
  input wire logic output_enable_n,
  output logic [WORD_WIDTH-1:0] data_out_bus,
  output logic output_ready_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [WORD_WIDTH-1:0] store[$];
  logic [WORD_WIDTH-1:0] stage = 4'h0;
  logic taken = 1'b0;
  initial output_ready_flag = 1'b0;
  ////////////////////////////////////////
  // Ripple the oldest word into the output stage once it is vacant.
  // flags and strobes alone
  task automatic refill();
    #RIPPLE_NS;
    if (!master_reset && !taken && !output_ready_flag && store.size() > 0) begin
      stage = store.pop_front();
      output_ready_flag = 1'b1;
      if (shift_out) begin
        #PULSE_NS output_ready_flag = 1'b0;
        // A strobe dropped during the pulse has already freed the stage.
        taken = shift_out;
        if (!taken) begin
          refill();
        end
      end
    end
  endtask
  // Producer side, called by the bench.
  task automatic load(input logic [WORD_WIDTH-1:0] word);
    // A shift-in pulse while master reset is high is lost.
    if (!master_reset) begin
      store.push_back(word);
    end
    refill();
  endtask
  always @(posedge master_reset) begin
    store.delete();
    output_ready_flag = 1'b0;
    taken = 1'b0;
  end
  always @(posedge shift_out) begin
    if (output_ready_flag) begin
      output_ready_flag = 1'b0;
      taken = 1'b1;
    end
  end
  always @(negedge shift_out) begin
    taken = 1'b0;
    refill();
  end
  assign data_out_bus = output_enable_n ? ~stage : stage;
endmodule

// File: verif/test_async_fifo_output_side.sv
module test_async_fifo_output_side
  import afo_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [3:0] din; logic [3:0] dout;} afo_row_type;
  afo_row_type rows[6] = '{'{4'ha, 4'ha}, '{4'h5, 4'h5}, '{4'h0, 4'h0},
    '{4'hf, 4'hf}, '{4'h3, 4'h3}, '{4'hc, 4'hc}};
  logic core_clk, reset, reset_device, burst_start, hold_mode, word_ready;
  logic [4:0] burst_words;
  logic [3:0] data_out_bus, word_data;
  logic output_ready_flag, shift_out, master_reset, output_enable_n, word_valid, busy;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  afo_host afo_host_inst (.CORE_CLK(core_clk), .RESET(reset), .RESET_DEVICE(reset_device),
    .BURST_START(burst_start), .BURST_WORDS(burst_words), .HOLD_MODE(hold_mode),
    .DATA_OUT_BUS(data_out_bus), .OUTPUT_READY_FLAG(output_ready_flag),
    .SHIFT_OUT(shift_out), .MASTER_RESET(master_reset), .OUTPUT_ENABLE_N(output_enable_n),
    .WORD_DATA(word_data), .WORD_VALID(word_valid), .WORD_READY(word_ready), .BUSY(busy));
  afo_device_model afo_device_model_inst (.master_reset(master_reset), .shift_out(shift_out),
    .output_enable_n(output_enable_n), .data_out_bus(data_out_bus),
    .output_ready_flag(output_ready_flag));
  ////////////////////////////////////////
  // Free-running clock, and a ceiling far above the few hundred cycles needed.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Waits for the sequencer to go idle, under a bound.
  task automatic settle();
    int n;
    n = 0;
    @(negedge core_clk);
    while (busy !== 1'b0 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    check("idle", 4'h0, {3'h0, busy});
  endtask
  // Takes one word from the user side; a spare cycle keeps strobes apart.
  task automatic pop(input logic [3:0] exp);
    int n;
    n = 0;
    while (word_valid !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    check("word", exp, word_data);
    word_ready = 1'b1;
    @(negedge core_clk);
    word_ready = 1'b0;
    @(negedge core_clk);
  endtask
  ////////////////////////////////////////
  initial begin
    {reset, reset_device, burst_start, hold_mode, word_ready} = 5'h10;
    burst_words = 5'h00;
    repeat (20) @(negedge core_clk);
    check("master reset", 4'h1, {3'h0, master_reset});
    check("enable n", 4'h1, {3'h0, output_enable_n});
    check("ready flag", 4'h0, {3'h0, output_ready_flag});
    reset = 1'b0;
    settle();
    check("enable n", 4'h0, {3'h0, output_enable_n});
    // Flag-paced words, one at a time.
    foreach (rows[i]) begin
      afo_device_model_inst.load(rows[i].din);
      pop(rows[i].dout);
    end
    settle();
    check("ready flag", 4'h0, {3'h0, output_ready_flag});
    check("last word", rows[5].dout, data_out_bus);
    // Burst of six against a four-word buffer while the user stalls.
    burst_words = 5'h06;
    burst_start = 1'b1;
    foreach (rows[i]) afo_device_model_inst.load(rows[i].din);
    @(negedge core_clk);
    burst_start = 1'b0;
    repeat (80) @(negedge core_clk);
    check("stalled busy", 4'h1, {3'h0, busy});
    foreach (rows[i]) pop(rows[i].dout);
    settle();
    // Strobe held high on an empty device, then a word falls through.
    hold_mode = 1'b1;
    repeat (6) @(negedge core_clk);
    check("held strobe", 4'h1, {3'h0, shift_out});
    afo_device_model_inst.load(4'hd);
    // Leave hold mode before the sequencer goes idle, so it does not re-arm.
    @(negedge core_clk);
    hold_mode = 1'b0;
    pop(4'hd);
    settle();
    // A word shifted in while the device is in reset is lost; the stage is kept.
    reset_device = 1'b1;
    @(negedge core_clk);
    reset_device = 1'b0;
    @(negedge core_clk);
    check("master reset", 4'h1, {3'h0, master_reset});
    afo_device_model_inst.load(4'h2);
    settle();
    repeat (10) @(negedge core_clk);
    check("ready flag", 4'h0, {3'h0, output_ready_flag});
    check("word valid", 4'h0, {3'h0, word_valid});
    check("kept word", 4'hd, data_out_bus);
    // Second reset of the controller in mid-run.
    reset = 1'b1;
    @(negedge core_clk);
    check("master reset", 4'h1, {3'h0, master_reset});
    reset = 1'b0;
    settle();
    complete_run();
  end
endmodule
